// ---- pkg/win_decode_pkg.sv ----
package win_decode_pkg;

    localparam int          ADDR_W      = 20;
    localparam int          DATA_W      = 32;
    localparam int          LOC_W       = 16;
    localparam int          FUNC_N      = 3;

    // 24-bit window region bases and tops (byte offsets)
    localparam logic [19:0] W24_C0_DATA_LO = 20'h00000;
    localparam logic [19:0] W24_C0_DATA_HI = 20'h3FFFC;
    localparam logic [19:0] W24_C0_PRAM_LO = 20'h40000;
    localparam logic [19:0] W24_C0_PRAM_HI = 20'h4FFFC;
    localparam logic [19:0] W24_C0_PROM_LO = 20'h50000;
    localparam logic [19:0] W24_C0_PROM_HI = 20'h53FFC;
    localparam logic [19:0] W24_C1_DATA_LO = 20'h80000;
    localparam logic [19:0] W24_C1_DATA_HI = 20'h9FFFC;
    localparam logic [19:0] W24_C1_PRAM_LO = 20'hC0000;
    localparam logic [19:0] W24_C1_PRAM_HI = 20'hCFFFC;
    localparam logic [19:0] W24_C1_PROM_LO = 20'hD0000;
    localparam logic [19:0] W24_C1_PROM_HI = 20'hD3FFC;

    // 16-bit window region bases and tops (byte offsets)
    localparam logic [19:0] W16_C0_DATA_LO = 20'h00000;
    localparam logic [19:0] W16_C0_DATA_HI = 20'h1FFFC;
    localparam logic [19:0] W16_C0_PRAM_LO = 20'h20000;
    localparam logic [19:0] W16_C0_PRAM_HI = 20'h27FFC;
    localparam logic [19:0] W16_C0_PROM_LO = 20'h28000;
    localparam logic [19:0] W16_C0_PROM_HI = 20'h29FFC;
    localparam logic [19:0] W16_C1_DATA_LO = 20'h40000;
    localparam logic [19:0] W16_C1_DATA_HI = 20'h4FFFC;
    localparam logic [19:0] W16_C1_PRAM_LO = 20'h60000;
    localparam logic [19:0] W16_C1_PRAM_HI = 20'h67FFC;
    localparam logic [19:0] W16_C1_PROM_LO = 20'h68000;
    localparam logic [19:0] W16_C1_PROM_HI = 20'h69FFC;

    // byte lane positions
    localparam int          LANE0       = 0;
    localparam int          LANE1       = 8;
    localparam int          LANE2       = 16;
    localparam int          LANE3       = 24;

    // memory select codes on the DSP side
    typedef enum logic [2:0] {
        MEM_NONE      = 3'h0,
        MEM_DATA      = 3'h1,
        MEM_PRAM      = 3'h2,
        MEM_PROM      = 3'h3
    } mem_sel_t;

    typedef enum logic [3:0] {
        ST_IDLE       = 4'b0001,
        ST_MEM        = 4'b0010,
        ST_WAIT       = 4'b0100,
        ST_DONE       = 4'b1000
    } state_t;

endpackage

// ---- rtl/win_region_decode.sv ----
`timescale 1ns/100ps
module win_region_decode
    import win_decode_pkg::*;
(
    input  wire logic [19:0]  offset_i,
    input  wire logic         packed_i,
    output mem_sel_t          sel_o,
    output logic              core_o,
    output logic [15:0]       index_o,
    output logic              wide_o
);
    import win_decode_pkg::*;

    function automatic logic in_range(input logic [19:0] a, input logic [19:0] lo, input logic [19:0] hi);
        // bits 1:0 only pick a byte lane, so an unaligned offset must not fall out of its region
        in_range = ({a[19:2], 2'b00} >= lo) && ({a[19:2], 2'b00} <= hi);
    endfunction

    // word index is offset minus base over the step of one 32-bit word
    function automatic logic [15:0] word_idx(input logic [19:0] a, input logic [19:0] lo);
        logic [19:0] diff;
        diff = a - lo;
        word_idx = diff[17:2];
    endfunction

    always_comb begin
        sel_o   = MEM_NONE;
        core_o  = 1'b0;
        index_o = 16'h0000;
        wide_o  = 1'b0;
        if (!packed_i) begin
            if (in_range(offset_i, W24_C0_DATA_LO, W24_C0_DATA_HI)) begin // RULE1 RULE3
                sel_o   = MEM_DATA;
                index_o = word_idx(offset_i, W24_C0_DATA_LO);
            end else if (in_range(offset_i, W24_C0_PRAM_LO, W24_C0_PRAM_HI)) begin // RULE5
                sel_o   = MEM_PRAM;
                wide_o  = 1'b1;
                index_o = word_idx(offset_i, W24_C0_PRAM_LO);
            end else if (in_range(offset_i, W24_C0_PROM_LO, W24_C0_PROM_HI)) begin // RULE6
                sel_o   = MEM_PROM;
                wide_o  = 1'b1;
                index_o = word_idx(offset_i, W24_C0_PROM_LO);
            end else if (in_range(offset_i, W24_C1_DATA_LO, W24_C1_DATA_HI)) begin // RULE7
                sel_o   = MEM_DATA;
                core_o  = 1'b1;
                index_o = word_idx(offset_i, W24_C1_DATA_LO);
            end else if (in_range(offset_i, W24_C1_PRAM_LO, W24_C1_PRAM_HI)) begin // RULE8
                sel_o   = MEM_PRAM;
                core_o  = 1'b1;
                wide_o  = 1'b1;
                index_o = word_idx(offset_i, W24_C1_PRAM_LO);
            end else if (in_range(offset_i, W24_C1_PROM_LO, W24_C1_PROM_HI)) begin // RULE9
                sel_o   = MEM_PROM;
                core_o  = 1'b1;
                wide_o  = 1'b1;
                index_o = word_idx(offset_i, W24_C1_PROM_LO);
            end
        end else begin
            // index counts pairs; the caller adds the half-word bit
            if (in_range(offset_i, W16_C0_DATA_LO, W16_C0_DATA_HI)) begin // RULE11
                sel_o   = MEM_DATA;
                index_o = word_idx(offset_i, W16_C0_DATA_LO);
            end else if (in_range(offset_i, W16_C0_PRAM_LO, W16_C0_PRAM_HI)) begin
                sel_o   = MEM_PRAM;
                wide_o  = 1'b1;
                index_o = word_idx(offset_i, W16_C0_PRAM_LO);
            end else if (in_range(offset_i, W16_C0_PROM_LO, W16_C0_PROM_HI)) begin
                sel_o   = MEM_PROM;
                wide_o  = 1'b1;
                index_o = word_idx(offset_i, W16_C0_PROM_LO);
            end else if (in_range(offset_i, W16_C1_DATA_LO, W16_C1_DATA_HI)) begin
                sel_o   = MEM_DATA;
                core_o  = 1'b1;
                index_o = word_idx(offset_i, W16_C1_DATA_LO);
            end else if (in_range(offset_i, W16_C1_PRAM_LO, W16_C1_PRAM_HI)) begin
                sel_o   = MEM_PRAM;
                core_o  = 1'b1;
                wide_o  = 1'b1;
                index_o = word_idx(offset_i, W16_C1_PRAM_LO);
            end else if (in_range(offset_i, W16_C1_PROM_LO, W16_C1_PROM_HI)) begin
                sel_o   = MEM_PROM;
                core_o  = 1'b1;
                wide_o  = 1'b1;
                index_o = word_idx(offset_i, W16_C1_PROM_LO);
            end
        end
    end

endmodule

// ---- rtl/pci_dsp_memory_window_decode.sv ----
`timescale 1ns/100ps
// Functional notes
// RULE1: 24-bit window: one DSP location per aligned 32-bit word, step four bytes.
// RULE2: 24-bit window 16-bit data: bits 15:8 lane 2, bits 7:0 lane 1.
// RULE3: 24-bit window offsets 0 to 0x3FFFC are first core data blocks 0-3.
// RULE4: 24-bit window 24-bit program data on lanes 2,1,0; lane 3 unused.
// RULE5: 24-bit window 0x40000-0x4FFFC is first core program RAM.
// RULE6: 24-bit window 0x50000-0x53FFC first core ROM; up to 0x7FFFC reserved.
// RULE7: 24-bit window 0x80000-0x9FFFC is second core data RAM blocks.
// RULE8: 24-bit window 0xC0000-0xCFFFC second core program RAM; 0xA0000-0xBFFFC reserved.
// RULE9: 24-bit window 0xD0000-0xD3FFC second core ROM; rest to 0xFFFFC reserved.
// RULE10: 16-bit window packs two words: lanes 3,2 one word, lanes 1,0 other.
// RULE11: 16-bit window first core data blocks contiguous, 32 KB of window each.
// RULE12: 24-bit location via 16-bit window moves upper 16 bits, lowest 8 ignored.
// RULE13: answer window accesses only while the function's memory enable is set.
// RULE14: reserved offsets read zero; writes there are dropped.
module pci_dsp_memory_window_decode
    import win_decode_pkg::*;
#(
    parameter int FUNC_NUM = win_decode_pkg::FUNC_N
) (
    input  wire logic                      clk_i,
    input  wire logic                      reset_i,
    input  wire logic                      clk_en_i,
    // host side target access
    input  wire logic                      req_i,
    input  wire logic                      write_i,
    input  wire logic                      packed_i,
    input  wire logic [1:0]                func_i,
    input  wire logic [19:0]               offset_i,
    input  wire logic [31:0]               wdata_i,
    input  wire logic [3:0]                byte_en_i,
    input  wire logic [FUNC_NUM-1:0]       mem_enable_i,
    output logic                           ack_o,
    output logic                           claim_o,
    output logic [31:0]                    rdata_o,
    // DSP memory side
    output logic                           mem_req_o,
    output logic                           mem_we_o,
    output logic                           mem_core_o,
    output logic [2:0]                     mem_sel_o,
    output logic [16:0]                    mem_addr_o,
    output logic [23:0]                    mem_wdata_o,
    output logic [2:0]                     mem_byte_en_o,
    input  wire logic                      mem_ack_i,
    input  wire logic [23:0]               mem_rdata_i
);
    import win_decode_pkg::*;

    state_t          state_q;
    mem_sel_t        dec_sel;
    logic            dec_core;
    logic [15:0]     dec_index;
    logic            dec_wide;
    logic            func_en;
    logic            half_q;
    logic            two_q;
    logic            wide_q;
    logic            packed_q;
    logic            write_q;
    logic            core_q;
    mem_sel_t        sel_q;
    logic [15:0]     index_q;
    logic [31:0]     wdata_q;
    logic [3:0]      be_q;
    logic [31:0]     rdata_acc_q;

    win_region_decode u_decode (
        .offset_i (offset_i),
        .packed_i (packed_i),
        .sel_o    (dec_sel),
        .core_o   (dec_core),
        .index_o  (dec_index),
        .wide_o   (dec_wide)
    );

    assign func_en = (int'(func_i) < FUNC_NUM) ? mem_enable_i[func_i] : 1'b0; // RULE13

    // write data for one DSP location, from the host word and the half selected
    function automatic logic [23:0] pack_wr(input logic [31:0] w, input logic pk, input logic hi_half,
                                            input logic wide);
        logic [15:0] h;
        h = hi_half ? w[31:16] : w[15:0];
        if (!pk)
            pack_wr = wide ? w[23:0] : {8'h00, w[23:8]}; // RULE2 RULE4
        else
            pack_wr = wide ? {h, 8'h00} : {8'h00, h}; // RULE10 RULE12
    endfunction

    // byte enables on the DSP side from the host lanes
    function automatic logic [2:0] pack_be(input logic [3:0] be, input logic pk, input logic hi_half,
                                           input logic wide);
        logic [1:0] b;
        b = hi_half ? be[3:2] : be[1:0];
        if (!pk)
            pack_be = wide ? be[2:0] : {1'b0, be[2:1]};
        else
            pack_be = wide ? {b, 1'b0} : {1'b0, b}; // RULE12
    endfunction

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
        end else if (clk_en_i) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (req_i && func_en) begin
                        state_q <= (dec_sel == MEM_NONE) ? ST_DONE : ST_MEM; // RULE14
                    end
                end
                ST_MEM: begin
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (mem_ack_i) begin
                        state_q <= (packed_q && !two_q) ? ST_MEM : ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // latch the request; in the packed window two locations follow each other
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            write_q  <= 1'b0;
            packed_q <= 1'b0;
            core_q   <= 1'b0;
            sel_q    <= MEM_NONE;
            index_q  <= 16'h0000;
            wide_q   <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            be_q     <= 4'h0;
            half_q   <= 1'b0;
            two_q    <= 1'b0;
        end else if (clk_en_i) begin
            if (state_q == ST_IDLE && req_i && func_en) begin
                write_q  <= write_i;
                packed_q <= packed_i;
                core_q   <= dec_core;
                sel_q    <= dec_sel;
                index_q  <= dec_index;
                wide_q   <= dec_wide;
                wdata_q  <= wdata_i;
                be_q     <= byte_en_i;
                half_q   <= 1'b0;
                two_q    <= 1'b0;
            end else if (state_q == ST_WAIT && mem_ack_i && packed_q && !two_q) begin
                half_q <= 1'b1; // RULE10
                two_q  <= 1'b1;
            end
        end
    end

    // DSP memory strobe; the lower half (lanes 1:0) is the even location
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mem_req_o     <= 1'b0;
            mem_we_o      <= 1'b0;
            mem_core_o    <= 1'b0;
            mem_sel_o     <= MEM_NONE;
            mem_addr_o    <= 17'h00000;
            mem_wdata_o   <= 24'h000000;
            mem_byte_en_o <= 3'h0;
        end else if (clk_en_i) begin
            mem_req_o <= 1'b0;
            if (state_q == ST_MEM) begin
                mem_req_o     <= 1'b1;
                mem_we_o      <= write_q;
                mem_core_o    <= core_q;
                mem_sel_o     <= sel_q;
                mem_addr_o    <= packed_q ? {index_q, half_q} : {1'b0, index_q}; // RULE1 RULE11
                mem_wdata_o   <= pack_wr(wdata_q, packed_q, half_q, wide_q);
                mem_byte_en_o <= pack_be(be_q, packed_q, half_q, wide_q);
            end
        end
    end

    // read data assembly onto host lanes
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_acc_q <= 32'h0000_0000;
        end else if (clk_en_i) begin
            if (state_q == ST_IDLE) begin
                rdata_acc_q <= 32'h0000_0000; // RULE14
            end else if (state_q == ST_WAIT && mem_ack_i) begin
                if (!packed_q) begin
                    rdata_acc_q <= wide_q ? {8'h00, mem_rdata_i} // RULE4
                                          : {8'h00, mem_rdata_i[15:0], 8'h00}; // RULE2
                end else if (!half_q) begin
                    rdata_acc_q[15:0]  <= wide_q ? mem_rdata_i[23:8] : mem_rdata_i[15:0]; // RULE12
                end else begin
                    rdata_acc_q[31:16] <= wide_q ? mem_rdata_i[23:8] : mem_rdata_i[15:0]; // RULE10
                end
            end
        end
    end

    // answer: one-cycle ack with data; claim shows the access was accepted
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ack_o   <= 1'b0;
            claim_o <= 1'b0;
            rdata_o <= 32'h0000_0000;
        end else if (clk_en_i) begin
            ack_o   <= (state_q == ST_DONE);
            claim_o <= (state_q == ST_IDLE) && req_i && func_en; // RULE13
            if (state_q == ST_DONE) begin
                rdata_o <= write_q ? 32'h0000_0000 : rdata_acc_q;
            end
        end
    end

endmodule

// ---- verification/win_decode_assertions.sv ----
`timescale 1ns/100ps
module win_decode_assertions
    import win_decode_pkg::*;
#(
    parameter int FUNC_NUM = win_decode_pkg::FUNC_N
) (
    input wire logic                clk_i,
    input wire logic                reset_i,
    input wire logic                clk_en_i,
    input wire logic                req_i,
    input wire logic                packed_i,
    input wire logic [1:0]          func_i,
    input wire logic [19:0]         offset_i,
    input wire logic [31:0]         wdata_i,
    input wire logic [FUNC_NUM-1:0] mem_enable_i,
    input wire logic                ack_o,
    input wire logic                claim_o,
    input wire logic [31:0]         rdata_o,
    input wire logic                mem_req_o,
    input wire logic                mem_we_o,
    input wire logic [2:0]          mem_sel_o,
    input wire logic [16:0]         mem_addr_o,
    input wire logic [23:0]         mem_wdata_o,
    input wire logic [2:0]          mem_byte_en_o,
    input wire logic                mem_ack_i
);
    logic busy_q;
    logic en;
    logic take;
    logic hit;
    logic [19:0] o;
    // regions that touch each other are tested as one span
    assign o = {offset_i[19:2], 2'b00};
    assign hit = packed_i ? (o <= W16_C0_PROM_HI || (o >= W16_C1_DATA_LO && o <= W16_C1_DATA_HI)
                             || (o >= W16_C1_PRAM_LO && o <= W16_C1_PROM_HI))
                          : (o <= W24_C0_PROM_HI || (o >= W24_C1_DATA_LO && o <= W24_C1_DATA_HI)
                             || (o >= W24_C1_PRAM_LO && o <= W24_C1_PROM_HI));
    assign en = (func_i < 2'(FUNC_NUM)) && mem_enable_i[func_i];
    assign take = clk_en_i && req_i && !busy_q && en;
    always_ff @(posedge clk_i) begin
        if (reset_i) busy_q <= 1'b0;
        else if (take) busy_q <= 1'b1;
        else if (ack_o) busy_q <= 1'b0;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence s_rsv_answer;
        claim_o ##1 (ack_o && rdata_o == 32'h0);
    endsequence
    sequence s_upper_half;
        mem_req_o && mem_addr_o[0];
    endsequence
    a_claim_on_take: assert property (take |=> claim_o) else $error("no claim after take");
    a_no_claim_off: assert property (clk_en_i && req_i && !busy_q && !en |=> !claim_o)
        else $error("claim for disabled function");
    a_reserved_answer: assert property (take && !hit |=> s_rsv_answer)
        else $error("reserved access answer wrong");
    a_reserved_no_mem: assert property (take && !hit |=> !mem_req_o [*3])
        else $error("reserved access reached memory");
    a_mem_req_launch: assert property (take && hit |-> ##2 mem_req_o)
        else $error("memory access not launched");
    a_ack_after_mem: assert property (mem_ack_i && busy_q && !packed_i |-> ##[1:3] ack_o)
        else $error("no ack after single location");
    a_lanes_wide: assert property (mem_req_o && mem_we_o && !packed_i |-> (mem_sel_o == 3'h1) ?
        mem_wdata_o[15:0] == wdata_i[23:8] : mem_wdata_o == wdata_i[23:0]) else $error("wide window lanes wrong");
    a_pair_halves: assert property (mem_req_o && mem_we_o && packed_i && mem_sel_o == 3'h1 |->
        mem_wdata_o[15:0] == (mem_addr_o[0] ? wdata_i[31:16] : wdata_i[15:0])) else $error("packed halves wrong");
    a_upper_only: assert property (mem_req_o && mem_we_o && packed_i && mem_sel_o != 3'h1 |->
        mem_byte_en_o == 3'b110 && mem_wdata_o[23:8] == (mem_addr_o[0] ? wdata_i[31:16] : wdata_i[15:0]))
        else $error("packed program write wrong");
    a_pair_order: assert property (mem_req_o && packed_i && !mem_addr_o[0] |-> ##[1:40] s_upper_half)
        else $error("second packed location missing");
endmodule

// ---- verification/dsp_mem_model.sv ----
`timescale 1ns/100ps
// dsp memory behind the window; unwritten words hold a pattern derived from the key
module dsp_mem_model (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic [2:0]  delay_i,
    input  wire logic        mem_req_i,
    input  wire logic        mem_we_i,
    input  wire logic [19:0] key_i,
    input  wire logic [23:0] mem_wdata_i,
    input  wire logic [2:0]  mem_byte_en_i,
    output logic             mem_ack_o,
    output logic [23:0]      mem_rdata_o
);
    logic [23:0] mem [int];
    int          pend = -1;
    logic [19:0] key_q;
    logic        we_q;
    logic [23:0] wd_q;
    logic [2:0]  be_q;
    function automatic logic [23:0] peek(input logic [19:0] k);
        return mem.exists(k) ? mem[k] : {k[3:0], k} ^ 24'hA5C3E1;
    endfunction
    function automatic logic [23:0] merge(input logic [23:0] old);
        for (int b = 0; b < 3; b++) if (be_q[b]) old[8*b+:8] = wd_q[8*b+:8];
        return old;
    endfunction
    initial begin
        mem_ack_o = 1'b0;
        mem_rdata_o = 24'h0;
    end
    always @(posedge clk_i) begin
        mem_ack_o <= 1'b0;
        mem_rdata_o <= ~mem_rdata_o; // between acks the last data and its inverse alternate every cycle
        if (reset_i) pend <= -1;
        else if (mem_req_i) begin
            key_q <= key_i;
            we_q <= mem_we_i;
            wd_q <= mem_wdata_i;
            be_q <= mem_byte_en_i;
            pend <= int'(delay_i);
        end else if (pend == 0) begin
            mem_ack_o <= 1'b1;
            mem_rdata_o <= peek(key_q);
            if (we_q) mem[key_q] = merge(peek(key_q));
            pend <= -1;
        end else if (pend > 0) pend <= pend - 1;
    end
endmodule

// ---- verification/pci_dsp_memory_window_decode_bench.sv ----
`timescale 1ns/100ps
module pci_dsp_memory_window_decode_bench;
    import win_decode_pkg::*;
    localparam logic [19:0] LO [2][6] = '{'{W24_C0_DATA_LO, W24_C0_PRAM_LO, W24_C0_PROM_LO, W24_C1_DATA_LO,
        W24_C1_PRAM_LO, W24_C1_PROM_LO}, '{W16_C0_DATA_LO, W16_C0_PRAM_LO, W16_C0_PROM_LO, W16_C1_DATA_LO,
        W16_C1_PRAM_LO, W16_C1_PROM_LO}};
    localparam logic [19:0] HI [2][6] = '{'{W24_C0_DATA_HI, W24_C0_PRAM_HI, W24_C0_PROM_HI, W24_C1_DATA_HI,
        W24_C1_PRAM_HI, W24_C1_PROM_HI}, '{W16_C0_DATA_HI, W16_C0_PRAM_HI, W16_C0_PROM_HI, W16_C1_DATA_HI,
        W16_C1_PRAM_HI, W16_C1_PROM_HI}};
    logic clk_i, reset_i, req_i, write_i, packed_i, ack_o, claim_o, mem_req_o, mem_we_o, mem_core_o, mem_ack_i;
    logic [1:0]  func_i;
    logic [19:0] offset_i;
    logic [31:0] wdata_i, rdata_o, wd;
    logic [2:0]  mem_enable_i, mem_sel_o, mem_byte_en_o, delay;
    logic [16:0] mem_addr_o;
    logic [23:0] mem_wdata_o, mem_rdata_i, nv, mk, sh [int];
    logic [20:0] la, lb;
    logic [15:0] hd;
    logic        p, w, f3, got, en, frz, clk_en_i;
    logic [1:0]  f;
    logic [19:0] o;
    int seed = 91, claims, mreqs, err_total, total_checks;
    pci_dsp_memory_window_decode i_pci_dsp_memory_window_decode (.clk_i(clk_i), .reset_i(reset_i),
        .clk_en_i(clk_en_i), .req_i(req_i), .write_i(write_i), .packed_i(packed_i), .func_i(func_i),
        .offset_i(offset_i), .wdata_i(wdata_i), .byte_en_i(4'hF), .mem_enable_i(mem_enable_i), .ack_o(ack_o),
        .claim_o(claim_o), .rdata_o(rdata_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_core_o(mem_core_o),
        .mem_sel_o(mem_sel_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_byte_en_o(mem_byte_en_o),
        .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));
    dsp_mem_model i_dsp_mem_model (.clk_i(clk_i), .reset_i(reset_i), .delay_i(delay), .mem_req_i(mem_req_o),
        .mem_we_i(mem_we_o), .key_i({mem_core_o, mem_sel_o[1:0], mem_addr_o}), .mem_wdata_i(mem_wdata_o),
        .mem_byte_en_i(mem_byte_en_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
    function automatic logic [20:0] loc(input logic pk, input logic [19:0] a, input logic h);
        logic [19:0] d;
        for (int i = 0; i < 6; i++) if (a >= LO[pk][i] && a <= HI[pk][i]) begin
            d = a - LO[pk][i];
            return {1'b1, i > 2, 2'(i % 3 + 1), pk ? 17'(d[19:1]) + 17'(h) : 17'(d[19:2])};
        end
        return 21'h0;
    endfunction
    function automatic logic [23:0] val(input logic [19:0] k);
        return sh.exists(k) ? sh[k] : {k[3:0], k} ^ 24'hA5C3E1;
    endfunction
    function automatic logic [31:0] rd_exp(input logic pk, input logic [20:0] a, input logic [20:0] b);
        logic [23:0] u = val(a[19:0]);
        logic [23:0] v = val(b[19:0]);
        if (!a[20]) return 32'h0;
        if (!pk) return a[18:17] == 2'd1 ? {8'h0, u[15:0], 8'h0} : {8'h0, u};
        return a[18:17] == 2'd1 ? {v[15:0], u[15:0]} : {v[23:8], u[23:8]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // host holds the request until ack is seen, then drops it; a disabled function never answers
    // offset bits 1:0 reuse the delay draw, the decoder must ignore them
    task automatic access;
        claims = 0;
        mreqs = 0;
        got = 1'b0;
        clk_en_i = !frz;
        {req_i, write_i, packed_i, func_i, offset_i, wdata_i} = {1'b1, w, p, f, o | 20'(delay[1:0]), wd};
        for (int n = 0; n < 120 && !got; n++) begin
            @(negedge clk_i);
            got = (ack_o === 1'b1);
            if (n == 1 && !clk_en_i) begin
                check("frozen claims", 32'(claims), 32'd0);
                clk_en_i = 1'b1;
            end
        end
        req_i = 1'b0;
    endtask
    always @(posedge clk_i) begin
        claims += int'(claim_o === 1'b1);
        mreqs += int'(mem_req_o === 1'b1);
    end
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #400000;
        err_total++;
        end_sim();
    end
    initial begin
        {reset_i, req_i, write_i, packed_i, func_i, offset_i, wdata_i, mem_enable_i, delay} = '0;
        reset_i = 1'b1;
        clk_en_i = 1'b1;
        frz = 1'b0;
        repeat (16) @(negedge clk_i);
        reset_i = 1'b0;
        for (int i = 0; i < 400; i++) begin
            @(negedge clk_i);
            // first region edges of both windows, including the word just past each top
            p = i < 36 ? (i >= 18) : 1'($random(seed));
            o = i < 36 ? (i % 3 == 0 ? LO[p][(i / 3) % 6] : HI[p][(i / 3) % 6] + 20'((i % 3) / 2 * 4))
                       : 20'($random(seed)) & (p ? 20'h7FFFC : 20'hFFFFC);
            la = loc(p, o, 1'b0);
            lb = loc(p, o, 1'b1);
            w = 1'($random(seed)) && la[18:17] != 2'd3;
            f = 2'($random(seed));
            f3 = (f == 2'd3) && (i % 4 != 0);
            if (f3) f = 2'd0;
            wd = $random(seed);
            delay = 3'($random(seed));
            frz = (i % 8 == 5);
            mem_enable_i = ($random(seed) & 3) != 0 ? 3'b111 : 3'($random(seed));
            en = f != 2'd3 && mem_enable_i[f];
            access();
            check("answered", 32'(got), 32'(en));
            if (en) begin
                check("claims", 32'(claims), 32'd1);
                check("mem accesses", 32'(mreqs), !la[20] ? 32'd0 : p ? 32'd2 : 32'd1);
                check("read data", rdata_o, w ? 32'h0 : rd_exp(p, la, lb));
                if (w && la[20]) for (int h = 0; h <= int'(p); h++) begin
                    la = loc(p, o, h[0]);
                    nv = val(la[19:0]);
                    hd = h[0] ? wd[31:16] : wd[15:0];
                    mk = la[18:17] == 2'd1 ? 24'h00FFFF : 24'hFFFFFF;
                    if (!p) nv = la[18:17] == 2'd1 ? {nv[23:16], wd[23:8]} : wd[23:0];
                    else nv = la[18:17] == 2'd1 ? {nv[23:16], hd} : {hd, nv[7:0]};
                    sh[la[19:0]] = nv;
                    check("stored", 32'(i_dsp_mem_model.peek(la[19:0]) & mk), 32'(nv & mk));
                end
            end else check("stray", 32'(claims + mreqs), 32'd0);
        end
        end_sim();
    end
endmodule
bind pci_dsp_memory_window_decode win_decode_assertions #(.FUNC_NUM(FUNC_NUM)) i_win_decode_assertions (
    .clk_i(clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .req_i(req_i), .packed_i(packed_i), .func_i(func_i),
    .offset_i(offset_i), .wdata_i(wdata_i), .mem_enable_i(mem_enable_i), .ack_o(ack_o), .claim_o(claim_o),
    .rdata_o(rdata_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_sel_o(mem_sel_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_byte_en_o(mem_byte_en_o), .mem_ack_i(mem_ack_i));
